// [rtl/rtcc_defines.svh]
`ifndef RTCC_DEFINES_SVH
`define RTCC_DEFINES_SVH
// i/o ram byte addresses
`define RTCC_ADDR_TEMP_HI   16'h2881
`define RTCC_ADDR_TEMP_LO   16'h2882
`define RTCC_ADDR_LUT_ADDR  16'h2887
`define RTCC_ADDR_LUT_DATA  16'h2888
`define RTCC_ADDR_LUT_STB   16'h2889
`define RTCC_ADDR_ALM_MIN   16'h289e
`define RTCC_ADDR_ALM_HR    16'h289f
`define RTCC_ADDR_CTRL      16'h28a0
`define RTCC_ADDR_TRIG      16'h28b4
// field positions
`define RTCC_AUTOINC_BIT    7
`define RTCC_RD_STB_BIT     1
`define RTCC_WR_STB_BIT     0
`define RTCC_COMP_EN_BIT    5
`define RTCC_BUSY_BIT       3
`define RTCC_TRIG_BIT       6
// reset values and nominal rate
`define RTCC_NOMINAL_RATE   19'h40000
`define RTCC_RATE_P_RST     17'h10000
`define RTCC_RATE_Q_RST     2'h0
// limiter bounds on the shifted temperature
`define RTCC_LIM_MAX        9'sd63
`define RTCC_LIM_MIN        (-9'sd64)
// control byte commit time
`define RTCC_CTRL_BUSY_NS   6000000
`define RTCC_CLK_NS         100
`define RTCC_CTRL_BUSY_CYC  (`RTCC_CTRL_BUSY_NS / `RTCC_CLK_NS)
// period field codes
`define RTCC_PER_MANUAL     3'h0
`define RTCC_PER_CONT       3'h7
`define RTCC_PER_EXP_BASE   3
`endif

// [rtl/rtcc_pkg.sv]
package rtcc_pkg;
  // power mode of the chip
  typedef enum logic [3:0] {
    RTCC_MISSION  = 4'h1,
    RTCC_BROWNOUT = 4'h2,
    RTCC_DISPLAY  = 4'h4,
    RTCC_SLEEP    = 4'h8
  } rtcc_mode_e;
  // register port write or read request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } rtcc_bus_s;
  // rate adjust pair
  typedef struct packed {
    logic [16:0] rate_p;
    logic [1:0]  rate_q;
  } rtcc_rate_s;
  // clock chain position
  typedef struct packed {
    logic       sec_tick;
    logic       min_tick;
    logic [5:0] minute;
    logic [4:0] hour;
  } rtcc_time_s;
endpackage

// [rtl/rtcc_lut_ram.sv]
`timescale 1ns/100ps
// 128 byte lookup store, one port, registered read
module rtcc_lut_ram (
  input  wire logic       core_clk,
  input  wire logic       en,
  input  wire logic       we,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  logic [7:0] mem [128];   // battery-backed storage, no reset

  // single access per cycle
  always_ff @(posedge core_clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
    if (en) begin
      rdata <= mem[addr];
    end
  end
endmodule // rtcc_lut_ram

// [rtl/rtcc_sched.sv]
`timescale 1ns/100ps
`include "rtcc_defines.svh"
// decides when a temperature measurement starts
module rtcc_sched (
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire rtcc_pkg::rtcc_mode_e mode,
  input  wire logic [2:0]          period,
  input  wire logic                trig,
  input  wire logic                sec_tick,
  input  wire logic                meas_busy,
  output logic                     start
);
  logic [9:0] sec_cnt_q;   // seconds since last automatic start
  logic [9:0] sec_cnt_d;
  logic [9:0] per_len;     // period in seconds
  logic       batt_mode;   // sleep or display-only
  logic       auto_due;
  logic       man_due;

  assign batt_mode = (mode == rtcc_pkg::RTCC_SLEEP) ||
                     (mode == rtcc_pkg::RTCC_DISPLAY);
  // 2^(3+n) seconds for codes 1..6
  assign per_len   = 10'h1 << (`RTCC_PER_EXP_BASE + period);
  // automatic starts in battery modes, any period but manual
  assign auto_due  = batt_mode && (period != `RTCC_PER_MANUAL) &&
                     ((period == `RTCC_PER_CONT) ||
                      (sec_tick && (sec_cnt_q + 10'h1 >= per_len)));
  // trigger honoured only in mission/brownout with period zero
  assign man_due   = !batt_mode && trig &&
                     (period == `RTCC_PER_MANUAL);
  assign start     = !meas_busy && (auto_due || man_due);
  assign sec_cnt_d = (auto_due && !meas_busy) ? 10'h0 :
                     (sec_tick ? sec_cnt_q + 10'h1 : sec_cnt_q);

  // second counter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sec_cnt_q <= 10'h0;
    end else begin
      sec_cnt_q <= sec_cnt_d;
    end
  end
endmodule // rtcc_sched

// [rtl/rtcc_top.sv]
`timescale 1ns/100ps
`include "rtcc_defines.svh"
// Operation
// - enable bit gates rate update per measurement
// - temperature split high byte, low three bits
// - address is temperature shifted right two
// - limit address to -64..+63
// - sign-extended entry plus 0x40000, 19 bits
// - upper 17 bits coarse, low 2 fine
// - seven-bit lookup address register
// - eight-bit lookup data register
// - strobes read one until access done
// - autoincrement address after each strobe
// - address held when autoincrement clear
// - trigger in mission, period in battery
// - periodic path needs no processor
// - second and minute tick events
// - alarm on minute and hour match
// - all three events on interrupt six
// - control byte busy locks out writes
// - table usable as storage when disabled
// - period codes: manual, 2^(3+n), continuous
// - trigger ignored unless manual, self-clears
module rtcc_top #(
  parameter int unsigned CTRL_BUSY_CYC = `RTCC_CTRL_BUSY_CYC
) (
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire rtcc_pkg::rtcc_bus_s  bus,
  output logic                [7:0] rdata,
  input  wire rtcc_pkg::rtcc_mode_e mode,
  input  wire rtcc_pkg::rtcc_time_s rtc_time,
  output logic                      meas_start,
  input  wire logic                 meas_done,
  input  wire logic          [10:0] meas_result,
  output rtcc_pkg::rtcc_rate_s      rate,
  output logic                      rate_load,
  output logic                      ext_int6,
  output logic                      second_irq,
  output logic                      minute_irq,
  output logic                      alarm_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [3:0] {
    RTCC_IDLE = 4'h1,   // nothing pending
    RTCC_CACC = 4'h2,   // compensation read issued
    RTCC_CSUM = 4'h4,   // compensation data back
    RTCC_PACC = 4'h8    // processor access issued
  } rtcc_st_e;

  rtcc_st_e    st_q, st_d;
  logic [10:0] temp_q;          // last measurement
  logic [6:0]  lut_address_q;   // indirect address
  logic        lut_autoinc_q;   // autoincrement flag
  logic [7:0]  lut_data_q;      // indirect data
  logic        rd_stb_q;        // read strobe
  logic        wr_stb_q;        // write strobe
  logic        comp_pend_q;     // compensation waiting
  logic        comp_en_q;       // automatic compensation on
  logic [2:0]  period_q;        // measurement period
  logic [7:0]  ctrl_hi_q;       // other control bits, stored only
  logic [22:0] busy_cnt_q;      // control byte commit timer
  logic        trig_q;          // measurement trigger
  logic        meas_busy_q;     // measurement in flight
  logic [5:0]  alm_min_q;
  logic [4:0]  alm_hr_q;
  logic        match_q;         // previous alarm match
  logic        sec_q, min_q, alm_q;
  logic [7:0]  rdata_q;
  rtcc_pkg::rtcc_rate_s rate_q;
  logic        rate_load_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire wr_addr  = bus.wr && (bus.addr == `RTCC_ADDR_LUT_ADDR);
  wire wr_data  = bus.wr && (bus.addr == `RTCC_ADDR_LUT_DATA);
  wire wr_stb   = bus.wr && (bus.addr == `RTCC_ADDR_LUT_STB);
  wire wr_amin  = bus.wr && (bus.addr == `RTCC_ADDR_ALM_MIN);
  wire wr_ahr   = bus.wr && (bus.addr == `RTCC_ADDR_ALM_HR);
  wire wr_trig  = bus.wr && (bus.addr == `RTCC_ADDR_TRIG);
  wire ctrl_busy = (busy_cnt_q != 23'h0);
  // writes during commit are dropped
  wire wr_ctrl  = bus.wr && (bus.addr == `RTCC_ADDR_CTRL) &&
                  !ctrl_busy;

  ////////////////////////////////////////////////////////////////////////////
  // lookup address arithmetic
  function automatic logic [6:0] lim_addr(input logic [10:0] t);
    logic signed [8:0] sh;
    sh = 9'($signed(t) >>> 2);
    if (sh > `RTCC_LIM_MAX) begin
      lim_addr = 7'h3f;
    end else if (sh < `RTCC_LIM_MIN) begin
      lim_addr = 7'h40;
    end else begin
      lim_addr = sh[6:0];
    end
  endfunction

  wire [6:0]  comp_addr = lim_addr(temp_q);
  wire [7:0]  ram_q;
  // sign-extend entry, add nominal
  wire [18:0] comp_sum  = `RTCC_NOMINAL_RATE +
                          {{11{ram_q[7]}}, ram_q};

  ////////////////////////////////////////////////////////////////////////////
  // ram port arbitration
  wire cpu_req  = rd_stb_q || wr_stb_q;
  wire go_comp  = (st_q == RTCC_IDLE) && comp_pend_q;
  wire go_cpu   = (st_q == RTCC_IDLE) && !comp_pend_q && cpu_req;
  wire ram_en   = go_comp || go_cpu;
  wire ram_we   = go_cpu && wr_stb_q && !rd_stb_q;
  wire [6:0] ram_a = go_comp ? comp_addr : lut_address_q;
  wire cpu_done = (st_q == RTCC_PACC);
  wire cpu_rd   = rd_stb_q;

  rtcc_lut_ram u_ram (
    .core_clk (core_clk),
    .en       (ram_en),
    .we       (ram_we),
    .addr     (ram_a),
    .wdata    (lut_data_q),
    .rdata    (ram_q)
  );

  // access sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      RTCC_IDLE: begin
        if (go_comp) begin
          st_d = RTCC_CACC;
        end else if (go_cpu) begin
          st_d = RTCC_PACC;
        end
      end
      RTCC_CACC: st_d = RTCC_CSUM;
      RTCC_CSUM: st_d = RTCC_IDLE;
      RTCC_PACC: st_d = RTCC_IDLE;
      default:   st_d = RTCC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= RTCC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect port registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lut_address_q <= 7'h0;
      lut_autoinc_q <= 1'b0;
      lut_data_q    <= 8'h0;
    end else begin
      if (wr_addr) begin
        lut_address_q <= bus.wdata[6:0];
        lut_autoinc_q <= bus.wdata[`RTCC_AUTOINC_BIT];
      end else if (cpu_done && lut_autoinc_q) begin
        lut_address_q <= lut_address_q + 7'h1;
      end
      if (wr_data) begin
        lut_data_q <= bus.wdata;
      end else if (cpu_done && cpu_rd) begin
        lut_data_q <= ram_q;
      end
    end
  end

  // strobes stay set until own access ends
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
    end else if (cpu_done) begin
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
    end else if (wr_stb && !cpu_req) begin
      rd_stb_q <= bus.wdata[`RTCC_RD_STB_BIT];
      wr_stb_q <= bus.wdata[`RTCC_WR_STB_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // measurement and compensation
  rtcc_sched u_sched (
    .core_clk  (core_clk),
    .srst      (srst),
    .mode      (mode),
    .period    (period_q),
    .trig      (trig_q),
    .sec_tick  (rtc_time.sec_tick),
    .meas_busy (meas_busy_q),
    .start     (meas_start)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      meas_busy_q <= 1'b0;
      trig_q      <= 1'b0;
      temp_q      <= 11'h0;
      comp_pend_q <= 1'b0;
    end else begin
      meas_busy_q <= meas_start | (meas_busy_q & ~meas_done);
      if (meas_done) begin
        temp_q <= meas_result;
        trig_q <= 1'b0;
      end else if (wr_trig) begin
        trig_q <= bus.wdata[`RTCC_TRIG_BIT];
      end
      // a new result beats the pending clear
      if (meas_done && comp_en_q) begin
        comp_pend_q <= 1'b1;
      end else if (go_comp) begin
        comp_pend_q <= 1'b0;
      end
    end
  end

  // load rate registers after summation
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rate_q      <= {`RTCC_RATE_P_RST, `RTCC_RATE_Q_RST};
      rate_load_q <= 1'b0;
    end else begin
      rate_load_q <= (st_q == RTCC_CSUM);
      if (st_q == RTCC_CSUM) begin
        rate_q.rate_p <= comp_sum[18:2];
        rate_q.rate_q <= comp_sum[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control byte with commit lockout
  always_ff @(posedge core_clk) begin
    if (srst) begin
      comp_en_q  <= 1'b0;
      period_q   <= 3'h0;
      ctrl_hi_q  <= 8'h0;
      busy_cnt_q <= 23'h0;
    end else if (wr_ctrl) begin
      comp_en_q  <= bus.wdata[`RTCC_COMP_EN_BIT];
      period_q   <= bus.wdata[2:0];
      ctrl_hi_q  <= bus.wdata & 8'hd0;
      busy_cnt_q <= 23'(CTRL_BUSY_CYC);
    end else if (ctrl_busy) begin
      busy_cnt_q <= busy_cnt_q - 23'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock chain events
  wire match_now = (rtc_time.minute == alm_min_q) &&
                   (rtc_time.hour == alm_hr_q);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      alm_min_q <= 6'h0;
      alm_hr_q  <= 5'h0;
      match_q   <= 1'b0;
      sec_q     <= 1'b0;
      min_q     <= 1'b0;
      alm_q     <= 1'b0;
    end else begin
      if (wr_amin) begin
        alm_min_q <= bus.wdata[5:0];
      end
      if (wr_ahr) begin
        alm_hr_q <= bus.wdata[4:0];
      end
      match_q <= match_now;
      sec_q   <= rtc_time.sec_tick;
      min_q   <= rtc_time.min_tick;
      alm_q   <= match_now && !match_q;
    end
  end

  assign second_irq = sec_q;
  assign minute_irq = min_q;
  assign alarm_irq  = alm_q;
  assign ext_int6   = sec_q | min_q | alm_q;

  ////////////////////////////////////////////////////////////////////////////
  // read mux, registered
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_q <= 8'h0;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `RTCC_ADDR_TEMP_HI:  rdata_q <= temp_q[10:3];
        `RTCC_ADDR_TEMP_LO:  rdata_q <= {temp_q[2:0], 5'h0};
        `RTCC_ADDR_LUT_ADDR: rdata_q <= {lut_autoinc_q, lut_address_q};
        `RTCC_ADDR_LUT_DATA: rdata_q <= lut_data_q;
        `RTCC_ADDR_LUT_STB:  rdata_q <= {6'h0, rd_stb_q, wr_stb_q};
        `RTCC_ADDR_ALM_MIN:  rdata_q <= {2'h0, alm_min_q};
        `RTCC_ADDR_ALM_HR:   rdata_q <= {3'h0, alm_hr_q};
        `RTCC_ADDR_CTRL:     rdata_q <= ctrl_hi_q |
                               {2'h0, comp_en_q, 1'b0, ctrl_busy, period_q};
        `RTCC_ADDR_TRIG:     rdata_q <= {1'b0, trig_q, 6'h0};
        default:             rdata_q <= 8'h0;
      endcase
    end
  end

  assign rdata     = rdata_q;
  assign rate      = rate_q;
  assign rate_load = rate_load_q;
endmodule // rtcc_top

// [tb/rtcc_top_asserts.sv]
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// port-side checks of the compensation block
module rtcc_top_asserts (
  input wire logic                 core_clk,
  input wire logic                 srst,
  input wire rtcc_pkg::rtcc_time_s rtc_time,
  input wire logic                 meas_start,
  input wire logic                 meas_done,
  input wire rtcc_pkg::rtcc_rate_s rate,
  input wire logic                 rate_load,
  input wire logic                 ext_int6,
  input wire logic                 second_irq,
  input wire logic                 minute_irq,
  input wire logic                 alarm_irq
);
  // one clock domain, one reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_sec_irq_follow: assert property (
    rtc_time.sec_tick |=> second_irq) else $error("second event lost");
  a_sec_irq_cause: assert property (
    second_irq |-> $past(rtc_time.sec_tick)) else $error("stray second");
  a_min_irq_follow: assert property (
    rtc_time.min_tick |=> minute_irq) else $error("minute event lost");
  a_int6_merge: assert property (
    ext_int6 == (second_irq | minute_irq | alarm_irq))
    else $error("interrupt six not the merge of events");
  a_alarm_single: assert property (
    alarm_irq |=> !alarm_irq) else $error("alarm longer than a pulse");
  a_rate_load_lat: assert property (
    rate_load |-> $past(meas_done, 4) || $past(meas_done, 5))
    else $error("rate load uncaused");
  a_rate_steady: assert property (
    !rate_load |-> $stable(rate)) else $error("rate moved without load");
  a_rate_window: assert property (
    rate_load |-> (rate >= 19'h3ff80) && (rate <= 19'h4007f))
    else $error("rate outside entry range");
  a_start_single: assert property (
    meas_start |=> !meas_start) else $error("start while in flight");
endmodule // rtcc_top_asserts

bind rtcc_top rtcc_top_asserts u_asserts (.core_clk, .srst, .rtc_time,
  .meas_start, .meas_done, .rate, .rate_load, .ext_int6, .second_irq,
  .minute_irq, .alarm_irq);

// [tb/tb_rtcc_top.sv]
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// self-checking bench for the compensation block
module tb_rtcc_top;
  logic                 core_clk = 1'b0;
  logic                 srst     = 1'b1;
  rtcc_pkg::rtcc_bus_s  bus      = '0;
  rtcc_pkg::rtcc_mode_e mode     = rtcc_pkg::RTCC_MISSION;
  rtcc_pkg::rtcc_time_s tm       = '0;
  rtcc_pkg::rtcc_rate_s rate;
  logic [7:0]           rdata, rv;
  logic [10:0]          res      = '0;
  logic                 meas_done = 1'b0;
  logic                 meas_start, rate_load, ext_int6;
  logic                 second_irq, minute_irq, alarm_irq;
  logic                 started  = 1'b0; // sticky start seen
  logic                 alarmed  = 1'b0; // sticky alarm seen
  logic                 loaded   = 1'b0; // sticky rate load seen
  int                   miscompares = 0;
  int                   check_count = 0;
  logic [15:0] ra[7] = '{16'h2887, 16'h2888, 16'h2889, 16'h289e,
                         16'h289f, 16'h28a0, 16'h2800};
  logic [10:0] tt[4] = '{11'h7ff, 11'h400, 11'h3ff, 11'h00b};

  rtcc_top #(.CTRL_BUSY_CYC(20)) DUT (.core_clk, .srst, .bus, .rdata,
    .mode, .rtc_time(tm), .meas_start, .meas_done, .meas_result(res),
    .rate, .rate_load, .ext_int6, .second_irq, .minute_irq, .alarm_irq);

  always #50 core_clk = ~core_clk;
  // catch short pulses
  always @(posedge core_clk) begin
    if (meas_start === 1'b1) started <= 1'b1;
    if (alarm_irq === 1'b1) alarmed <= 1'b1;
    if (rate_load === 1'b1) loaded <= 1'b1;
  end

  task chk(input logic [18:0] s, input logic [18:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk) bus = '{1'b1, 1'b0, a, d};
    @(negedge core_clk) bus = '0;
  endtask
  task rd(input logic [15:0] a);
    @(negedge core_clk) bus = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk) bus = '0;
    @(negedge core_clk) rv = rdata;
  endtask
  // strobe, then poll until cleared
  task stb(input logic [7:0] s);
    wr(16'h2889, s);
    for (int i = 0; i < 20; i++) begin
      rd(16'h2889);
      if (rv[1:0] === 2'b00) break;
    end
    chk(rv[1:0], 2'b00);
  endtask
  // one second tick from the counter chain
  task tick;
    @(negedge core_clk) tm.sec_tick = 1'b1;
    @(negedge core_clk) tm.sec_tick = 1'b0;
  endtask
  function logic [7:0] lut(input logic [6:0] a);
    return {1'b0, a} * 8'h03;
  endfunction
  // expected rate word for a temperature
  function logic [18:0] ex(input logic [10:0] t);
    logic signed [10:0] s;
    logic [7:0]         e;
    s = $signed(t) >>> 2;
    if (s > 63) s = 63;
    else if (s < -64) s = -64;
    e = lut(s[6:0]);
    return 19'h40000 + {{11{e[7]}}, e};
  endfunction

  task t_reset;
    chk(rate, 19'h40000);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(rv, 8'h00);
    end
  endtask
  // full table load with autoincrement, then one random read
  task t_load;
    wr(16'h2887, 8'h80);
    for (int i = 0; i < 128; i++) begin
      wr(16'h2888, lut(i[6:0]));
      stb(8'h01);
    end
    rd(16'h2887);
    chk(rv, 8'h80);
    wr(16'h2887, 8'h23);
    stb(8'h02);
    rd(16'h2888);
    chk(rv, lut(7'h23));
    rd(16'h2887);
    chk(rv, 8'h23);
  endtask
  task t_comp;
    wr(16'h28a0, 8'h20);
    rd(16'h28a0);
    chk(rv, 8'h28);
    wr(16'h28a0, 8'h00);
    repeat (25) @(negedge core_clk);
    rd(16'h28a0);
    chk(rv, 8'h20);
    foreach (tt[k]) begin
      started = 1'b0;
      loaded = 1'b0;
      wr(16'h28b4, 8'h40);
      repeat (3) @(negedge core_clk);
      chk(started, 1'b1);
      @(negedge core_clk) res = tt[k];
      meas_done = 1'b1;
      @(negedge core_clk) meas_done = 1'b0;
      repeat (5) @(negedge core_clk);
      chk(rate, ex(tt[k]));
      chk(loaded, 1'b1);
      rd(16'h2881);
      chk(rv, tt[k][10:3]);
      rd(16'h2882);
      chk(rv[7:5], tt[k][2:0]);
      rd(16'h28b4);
      chk(rv[6], 1'b0);
    end
  endtask
  // sleep, continuous period, compensation off
  task t_off;
    wr(16'h28a0, 8'h07);
    mode = rtcc_pkg::RTCC_SLEEP;
    started = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(started, 1'b1);
    loaded = 1'b0;
    @(negedge core_clk) res = 11'h400;
    meas_done = 1'b1;
    @(negedge core_clk) meas_done = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(rate, ex(11'h00b));
    chk(loaded, 1'b0);
  endtask
  // display-only, 16 s period, trigger ignored
  task t_per;
    repeat (20) @(negedge core_clk);
    wr(16'h28a0, 8'h01);
    mode = rtcc_pkg::RTCC_DISPLAY;
    rd(16'h28a0);
    chk(rv, 8'h09);
    started = 1'b0;
    @(negedge core_clk) meas_done = 1'b1;
    @(negedge core_clk) meas_done = 1'b0;
    for (int i = 0; i < 17 && !started; i++) tick;
    chk(started, 1'b1);
    @(negedge core_clk) meas_done = 1'b1;
    @(negedge core_clk) meas_done = 1'b0;
    started = 1'b0;
    wr(16'h28b4, 8'h40);
    repeat (15) tick;
    chk(started, 1'b0);
    tick;
    chk(started, 1'b1);
  endtask
  task t_irq;
    @(negedge core_clk) tm.sec_tick = 1'b1;
    @(negedge core_clk) tm.sec_tick = 1'b0;
    chk({second_irq, ext_int6}, 2'b11);
    @(negedge core_clk) tm.min_tick = 1'b1;
    @(negedge core_clk) tm.min_tick = 1'b0;
    chk({minute_irq, ext_int6}, 2'b11);
    wr(16'h289e, 8'h05);
    wr(16'h289f, 8'h03);
    @(negedge core_clk) alarmed = 1'b0;
    tm.minute = 6'h05;
    tm.hour = 5'h03;
    repeat (4) @(negedge core_clk);
    chk(alarmed, 1'b1);
  endtask

  task wrap_up;
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(negedge core_clk);
    srst = 1'b0;
    t_reset;
    t_load;
    t_comp;
    t_off;
    t_irq;
    t_per;
    wrap_up;
  end
  // hang guard
  initial begin
    #5000000;
    miscompares++;
    wrap_up;
  end
endmodule // tb_rtcc_top
